/* verilog/cem_pkg.sv */
// Shared constants for the capacitor test and limit alarm block
package cem_pkg;
  // Clock and time
  localparam int CLK_HZ = 40_000_000;
  localparam int PERIOD_UNIT_S = 10;
  localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_S * CLK_HZ;
  localparam int CAP_TICK_CYCLES = 4000;
  localparam int CAP_FINE_DIV = 100;
  // Geometry
  localparam int NUM_CHAN = 11;
  localparam int NUM_ALARM = 14;
  // Register offsets
  localparam logic [7:0] REG_CTL = 8'h00;
  localparam logic [7:0] REG_MON_STATUS = 8'h01;
  localparam logic [7:0] REG_MON_MASK = 8'h02;
  localparam logic [7:0] REG_ALARM = 8'h03;
  localparam logic [7:0] REG_ALARM_MASK = 8'h04;
  localparam logic [7:0] REG_ALARM_CLEAR = 8'h05;
  localparam logic [7:0] REG_PERIOD = 8'h06;
  localparam logic [7:0] REG_CAP_RESULT = 8'h07;
  localparam logic [7:0] REG_ESR_RESULT = 8'h08;
  localparam logic [7:0] REG_CELL_COUNT = 8'h09;
  localparam logic [7:0] REG_FB_DAC = 8'h0a;
  localparam logic [7:0] REG_SHUNT = 8'h0b;
  localparam logic [7:0] REG_LIMIT_BASE = 8'h10;
  localparam logic [7:0] REG_MEAS_BASE = 8'h20;
  // Control bits
  localparam int CTL_START = 0;
  localparam int CTL_AUX_BUF = 1;
  localparam int CTL_CAP_SCALE = 2;
  // Monitor status bits
  localparam int MON_RUNNING = 0;
  localparam int MON_CAP_DONE = 1;
  localparam int MON_ESR_DONE = 2;
  localparam int MON_CAP_FAILED = 3;
  localparam int MON_ESR_FAILED = 4;
  // Channels
  localparam logic [3:0] CH_AUX = 4'h4;
  localparam logic [3:0] CH_VIN = 4'h5;
  localparam logic [3:0] CH_STACK = 4'h6;
  localparam logic [3:0] CH_VOUT = 4'h7;
  localparam logic [3:0] CH_IIN = 4'h8;
  localparam logic [3:0] CH_ICHG = 4'h9;
  localparam logic [3:0] CH_DTEMP = 4'ha;
  localparam logic [3:0] CH_LAST = 4'ha;
  // Channel of each alarm bit; bits 0 and 1 cover all four cells
  localparam logic [3:0] ALARM_CHAN [NUM_ALARM] = '{4'h0, 4'h0, CH_AUX, CH_AUX,
    CH_VIN, CH_VIN, CH_STACK, CH_STACK, CH_VOUT, CH_VOUT, CH_IIN, CH_ICHG,
    CH_DTEMP, CH_DTEMP};
  // Set bit means the alarm fires above its limit, clear means below
  localparam logic [13:0] ALARM_IS_OVER = 14'h26aa;
  // Reset values
  localparam logic [3:0] FB_DAC_RESET = 4'hf;
  localparam logic [15:0] SHUNT_RESET = 16'h3999;
  localparam logic [1:0] ESR_CUR_RESET = 2'h3;
  // ESR above 1024 sense resistances, in units of one sixty-fourth
  localparam logic [16:0] ESR_FAIL_LIMIT = 17'h10000;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT_CHG = 4'b0010,
    ST_DISCH = 4'b0100,
    ST_ESR = 4'b1000
  } cem_state_t;
endpackage : cem_pkg

/* verilog/cem_meas_mem.sv */
// Measurement store with registered read data
module cem_meas_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 11,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk_sys,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end
endmodule : cem_meas_mem

/* verilog/cem_monitor.sv */
// Capacitance/ESR test sequencer, ADC limit alarms and alert line
module cem_monitor
  import cem_pkg::*;
#(
  parameter int UNIT_CYCLES = PERIOD_UNIT_CYCLES,
  parameter int TICK_CYCLES = CAP_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Pins
  input wire logic power_fail,
  input wire logic stack_charged_indicator,
  input wire logic cell_count_select_low,
  input wire logic cell_count_select_high,
  output logic smbalert_out,
  output logic smbalert_oe,
  // Alert response answered by the bus slave
  input wire logic ara_done,
  // ADC converter
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  output logic adc_start,
  output logic [3:0] adc_channel,
  output logic aux_buffer_en,
  // Analog test circuits
  input wire logic disch_done,
  input wire logic esr_done,
  input wire logic [16:0] esr_value,
  output logic charger_disable,
  output logic discharge_en,
  output logic esr_run,
  output logic [1:0] esr_current,
  output logic backup_mode,
  // Analog configuration
  output logic [3:0] fb_ref_code,
  output logic [15:0] shunt_code
);
  // Synchronisers for the four pin inputs
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  assign pin_raw = {cell_count_select_high, cell_count_select_low,
                    stack_charged_indicator, power_fail};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate
  logic pf;
  logic charged;
  assign pf = pin_sync[0];
  assign charged = pin_sync[1];

  // Registers
  logic [2:0] ctl;
  logic [4:0] mon_status;
  logic [4:0] mon_prev;
  logic [4:0] mon_mask;
  logic [13:0] alarm;
  logic [13:0] alarm_mask;
  logic [15:0] period;
  logic [15:0] cap_result;
  logic [15:0] esr_result;
  logic [1:0] cell_count;
  logic [15:0] limit [NUM_ALARM];
  logic [15:0] rdata_reg;
  logic mem_sel;
  logic [15:0] mem_q;
  cem_state_t state;
  logic period_due;
  logic begin_test;
  logic wr_ctl;
  logic wr_clear;

  assign wr_ctl = reg_wr && reg_addr == REG_CTL;
  assign wr_clear = reg_wr && reg_addr == REG_ALARM_CLEAR;
  assign begin_test = state == ST_IDLE && (ctl[CTL_START] || period_due);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl <= 3'h0;
    end else if (wr_ctl) begin
      // A host write wins so a new request is never lost
      ctl <= reg_wdata[2:0];
    end else if (begin_test) begin
      ctl[CTL_START] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mon_mask <= 5'h00;
      alarm_mask <= 14'h0000;
      period <= 16'h0000;
      fb_ref_code <= FB_DAC_RESET;
      shunt_code <= SHUNT_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_MON_MASK: mon_mask <= reg_wdata[4:0];
        REG_ALARM_MASK: alarm_mask <= reg_wdata[13:0];
        REG_PERIOD: period <= reg_wdata;
        REG_FB_DAC: fb_ref_code <= reg_wdata[3:0];
        REG_SHUNT: shunt_code <= reg_wdata;
        default: ;
      endcase
    end
  end

  // limit levels, one per alarm bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_ALARM; i++) begin
        limit[i] <= 16'h0000;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_ALARM; i++) begin
        if (reg_addr == REG_LIMIT_BASE + 8'(i)) begin
          limit[i] <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cell_count <= 2'h0;
    end else begin
      cell_count <= pin_sync[3:2];
    end
  end

  logic booted;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      booted <= 1'b0;
      adc_start <= 1'b0;
      adc_channel <= 4'h0;
    end else begin
      booted <= 1'b1;
      adc_start <= !booted || adc_done;
      if (adc_done) begin
        adc_channel <= (adc_channel == CH_LAST) ? 4'h0 : adc_channel + 4'h1;
      end
    end
  end

  // results kept as full signed words
  cem_meas_mem #(
    .WIDTH(16),
    .DEPTH(NUM_CHAN),
    .AW(4)
  ) u_meas (
    .clk_sys(clk_sys),
    .wr_en(adc_done),
    .wr_addr(adc_channel),
    .wr_data(adc_data),
    .rd_addr(reg_addr[3:0]),
    .rd_data(mem_q)
  );

  // compare each new sample against its limits
  logic [13:0] hit;
  generate
    for (gi = 0; gi < NUM_ALARM; gi++) begin : g_limit
      logic chan_match;
      logic beyond;
      assign chan_match = (gi < 2) ? (adc_channel < CH_AUX)
                                   : (adc_channel == ALARM_CHAN[gi]);
      // temperature and auxiliary use the same comparators
      assign beyond = ALARM_IS_OVER[gi] ? ($signed(adc_data) > $signed(limit[gi]))
                                        : ($signed(adc_data) < $signed(limit[gi]));
      assign hit[gi] = adc_done && chan_match && beyond && alarm_mask[gi];
    end
  endgenerate

  // only a written one clears, a new hit wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alarm <= 14'h0000;
    end else begin
      alarm <= (alarm & ~(wr_clear ? reg_wdata[13:0] : 14'h0000)) | hit;
    end
  end

  // Alert line, open drain
  logic new_alarm;
  logic mon_event;
  assign new_alarm = |(hit & ~alarm);
  // rising edge of masked status bit
  assign mon_event = |(mon_status & ~mon_prev & mon_mask);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mon_prev <= 5'h00;
      smbalert_oe <= 1'b0;
      smbalert_out <= 1'b0;
    end else begin
      mon_prev <= mon_status;
      smbalert_out <= 1'b0;
      if (new_alarm || mon_event) begin
        smbalert_oe <= 1'b1;
      end else if (ara_done) begin
        smbalert_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aux_buffer_en <= 1'b0;
      backup_mode <= 1'b0;
    end else begin
      aux_buffer_en <= ctl[CTL_AUX_BUF];
      // backup follows the power fail input
      backup_mode <= pf;
    end
  end

  // repeat timer, counts only while idle after a test
  logic armed;
  logic [31:0] unit_cnt;
  logic [15:0] units;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armed <= 1'b0;
      unit_cnt <= 32'h0;
      units <= 16'h0;
      period_due <= 1'b0;
    end else if (state != ST_IDLE || period == 16'h0 || !armed) begin
      armed <= armed || begin_test;
      unit_cnt <= 32'h0;
      units <= 16'h0;
      period_due <= 1'b0;
    end else if (!period_due) begin
      if (unit_cnt == 32'(UNIT_CYCLES - 1)) begin
        unit_cnt <= 32'h0;
        units <= units + 16'h1;
        period_due <= (units + 16'h1) >= period;
      end else begin
        unit_cnt <= unit_cnt + 32'h1;
      end
    end
  end

  // tick length set by scale bit
  logic [15:0] tick_cnt;
  logic [15:0] tick_len;
  logic [15:0] cap_ticks;
  assign tick_len = ctl[CTL_CAP_SCALE] ? 16'(TICK_CYCLES / CAP_FINE_DIV)
                                       : 16'(TICK_CYCLES);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 16'h0;
      cap_ticks <= 16'h0;
    end else if (state != ST_DISCH) begin
      tick_cnt <= 16'h0;
      cap_ticks <= 16'h0;
    end else if (tick_cnt >= tick_len - 16'h1) begin
      tick_cnt <= 16'h0;
      // Saturate so an oversized stack reads full scale, not wrapped
      if (cap_ticks != 16'hffff) begin
        cap_ticks <= cap_ticks + 16'h1;
      end
    end else begin
      tick_cnt <= tick_cnt + 16'h1;
    end
  end

  // Test sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      mon_status <= 5'h00;
      cap_result <= 16'h0;
      esr_result <= 16'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (begin_test) begin
            mon_status <= 5'h01;
            state <= ST_WAIT_CHG;
          end
        end
        ST_WAIT_CHG: begin
          if (pf) begin
            mon_status <= 5'h18;
            state <= ST_IDLE;
          end else if (charged) begin
            state <= ST_DISCH;
          end
        end
        ST_DISCH: begin
          if (pf || !charged) begin
            mon_status <= 5'h18;
            state <= ST_IDLE;
          end else if (disch_done) begin
            cap_result <= cap_ticks;
            mon_status[MON_CAP_DONE] <= 1'b1;
            state <= ST_ESR;
          end
        end
        ST_ESR: begin
          if (pf) begin
            mon_status[MON_RUNNING] <= 1'b0;
            mon_status[MON_ESR_FAILED] <= 1'b1;
            state <= ST_IDLE;
          end else if (esr_done) begin
            mon_status[MON_RUNNING] <= 1'b0;
            if (esr_value > ESR_FAIL_LIMIT) begin
              mon_status[MON_ESR_FAILED] <= 1'b1;
            end else begin
              esr_result <= esr_value[15:0];
              mon_status[MON_ESR_DONE] <= 1'b1;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          mon_status <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      charger_disable <= 1'b0;
      discharge_en <= 1'b0;
      esr_run <= 1'b0;
      esr_current <= ESR_CUR_RESET;
    end else begin
      charger_disable <= state == ST_DISCH;
      discharge_en <= state == ST_DISCH;
      esr_run <= state == ST_ESR;
      // Higher ESR needs less current to stay in range
      if (esr_result >= 16'h4000) begin
        esr_current <= 2'h0;
      end else if (esr_result >= 16'h1000) begin
        esr_current <= 2'h1;
      end else if (esr_result >= 16'h0400) begin
        esr_current <= 2'h2;
      end else begin
        esr_current <= 2'h3;
      end
    end
  end

  // Read path, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0;
      mem_sel <= 1'b0;
    end else begin
      mem_sel <= reg_rd && reg_addr >= REG_MEAS_BASE &&
                 reg_addr <= REG_MEAS_BASE + 8'(CH_LAST);
      rdata_reg <= 16'h0;
      if (reg_rd) begin
        case (reg_addr)
          REG_CTL: rdata_reg <= {13'h0, ctl};
          REG_MON_STATUS: rdata_reg <= {11'h0, mon_status};
          REG_MON_MASK: rdata_reg <= {11'h0, mon_mask};
          REG_ALARM: rdata_reg <= {2'h0, alarm};
          REG_ALARM_MASK: rdata_reg <= {2'h0, alarm_mask};
          REG_PERIOD: rdata_reg <= period;
          REG_CAP_RESULT: rdata_reg <= cap_result;
          REG_ESR_RESULT: rdata_reg <= esr_result;
          REG_CELL_COUNT: rdata_reg <= {14'h0, cell_count};
          REG_FB_DAC: rdata_reg <= {12'h0, fb_ref_code};
          REG_SHUNT: rdata_reg <= shunt_code;
          default: begin
            for (int i = 0; i < NUM_ALARM; i++) begin
              if (reg_addr == REG_LIMIT_BASE + 8'(i)) begin
                rdata_reg <= limit[i];
              end
            end
          end
        endcase
      end
    end
  end
  // Memory output is itself a register, so this is a flop-to-flop select
  assign reg_rdata = mem_sel ? mem_q : rdata_reg;
endmodule : cem_monitor

/* tb/cem_adc_model.sv */
// Behavioural converter answering the block's conversion requests
module cem_adc_model
  import cem_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Requests from the block
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  // Stimulus from the bench
  input wire logic [10:0][15:0] vals,
  input wire logic [3:0] lat,
  // Results
  output logic adc_done,
  output logic [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy;
  logic [3:0] cnt;
  logic [3:0] ch;

  // one channel per request, 16-bit word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      ch <= 4'h0;
      adc_done <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      adc_done <= 1'b0;
      // Data toggles outside the result cycle, so stale reads show up
      adc_data <= ~adc_data;
      if (adc_start) begin
        busy <= 1'b1;
        cnt <= lat;
        ch <= adc_channel;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= vals[ch];
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : cem_adc_model

/* tb/cem_monitor_properties.sv */
// Port-level assertions for the capacitor monitor
module cem_monitor_properties
  import cem_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port and pins
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic power_fail,
  input wire logic stack_charged_indicator,
  input wire logic ara_done,
  input wire logic smbalert_out,
  input wire logic smbalert_oe,
  // Converter and test circuits
  input wire logic adc_done,
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  input wire logic aux_buffer_en,
  input wire logic disch_done,
  input wire logic charger_disable,
  input wire logic discharge_en,
  input wire logic esr_run,
  input wire logic backup_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] pf_hist;
  logic [3:0] chg_hist;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Pin history, so a change still inside the synchroniser excuses the check
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pf_hist <= 4'hf;
      chg_hist <= 4'h0;
    end else begin
      pf_hist <= {pf_hist[2:0], power_fail};
      chg_hist <= {chg_hist[2:0], stack_charged_indicator};
    end
  end

  chk_adc_restart: assert property (adc_done |=> adc_start)
    else $error("no new conversion after a result");
  chk_chan_wrap: assert property (adc_done && adc_channel == CH_LAST |=> adc_channel == 4'h0)
    else $error("channel did not wrap");
  chk_chan_step: assert property (adc_done && adc_channel != CH_LAST
    |=> adc_channel == $past(adc_channel) + 4'h1)
    else $error("channel did not advance");
  chk_alert_release: assert property ($fell(smbalert_oe) |-> $past(ara_done))
    else $error("alert released without alert response");
  chk_alert_low_only: assert property (smbalert_out == 1'b0)
    else $error("alert line driven high");
  chk_backup_enter: assert property (power_fail [*4] |-> backup_mode)
    else $error("no backup after power failure");
  chk_charger_off: assert property (discharge_en |-> charger_disable && !esr_run)
    else $error("charger active during discharge");
  chk_esr_follows: assert property (discharge_en && disch_done && !power_fail
    && pf_hist == 4'h0 && chg_hist == 4'hf |-> ##2 esr_run)
    else $error("ESR test did not follow discharge");
  chk_aux_buffer: assert property (reg_wr && reg_addr == REG_CTL
    |-> ##2 aux_buffer_en == $past(reg_wdata[CTL_AUX_BUF], 2))
    else $error("buffer enable does not follow control");
endmodule : cem_monitor_properties

bind cem_monitor cem_monitor_properties i_cem_monitor_properties (.clk_sys(clk_sys),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .power_fail(power_fail), .stack_charged_indicator(stack_charged_indicator),
  .ara_done(ara_done), .smbalert_out(smbalert_out), .smbalert_oe(smbalert_oe),
  .adc_done(adc_done), .adc_start(adc_start), .adc_channel(adc_channel),
  .aux_buffer_en(aux_buffer_en), .disch_done(disch_done), .charger_disable(charger_disable),
  .discharge_en(discharge_en), .esr_run(esr_run), .backup_mode(backup_mode));

/* tb/cem_monitor_bench.sv */
// Self-checking bench for the capacitor monitor
module cem_monitor_bench
  import cem_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, resetn, reg_wr, reg_rd, power_fail, stack_charged_indicator;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, shunt_code, d, cap_coarse;
  logic smbalert_out, smbalert_oe, ara_done, adc_done, adc_start, aux_buffer_en;
  logic [15:0] adc_data;
  logic [3:0] adc_channel, fb_ref_code, adc_lat;
  logic disch_done, esr_done, charger_disable, discharge_en, esr_run, backup_mode;
  logic [16:0] esr_value;
  logic [1:0] esr_current, cell_sel;
  logic [10:0][15:0] adc_vals;
  int n_mismatch = 0;
  int cmp_count = 0;

  // Short counts keep the run small
  cem_monitor #(.UNIT_CYCLES(20), .TICK_CYCLES(200)) i_cem_monitor (.clk_sys(clk_sys),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_fail(power_fail),
    .stack_charged_indicator(stack_charged_indicator), .cell_count_select_low(cell_sel[0]),
    .cell_count_select_high(cell_sel[1]), .smbalert_out(smbalert_out),
    .smbalert_oe(smbalert_oe), .ara_done(ara_done), .adc_done(adc_done),
    .adc_data(adc_data), .adc_start(adc_start), .adc_channel(adc_channel),
    .aux_buffer_en(aux_buffer_en), .disch_done(disch_done), .esr_done(esr_done),
    .esr_value(esr_value), .charger_disable(charger_disable), .discharge_en(discharge_en),
    .esr_run(esr_run), .esr_current(esr_current), .backup_mode(backup_mode),
    .fb_ref_code(fb_ref_code), .shunt_code(shunt_code));
  cem_adc_model i_cem_adc_model (.clk_sys(clk_sys), .resetn(resetn), .adc_start(adc_start),
    .adc_channel(adc_channel), .vals(adc_vals), .lat(adc_lat), .adc_done(adc_done),
    .adc_data(adc_data));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stuck();
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    report_and_stop();
  endtask : stuck

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask : rdchk

  task automatic poll(input logic [7:0] a, input logic [15:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      rd(a, d);
      if ((d & m) != 16'h0000) return;
    end
    stuck();
  endtask : poll

  // Select 0 discharge, 1 ESR, 2 backup
  task automatic wait_for(input int s, input logic lvl);
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk_sys);
      if ((s == 0 ? discharge_en : s == 1 ? esr_run : backup_mode) === lvl) return;
    end
    stuck();
  endtask : wait_for

  // Select 0 alert response, 1 discharge end, 2 ESR end
  task automatic pulse(input int s);
    @(posedge clk_sys);
    ara_done <= (s == 0);
    disch_done <= (s == 1);
    esr_done <= (s == 2);
    @(posedge clk_sys);
    ara_done <= 1'b0;
    disch_done <= 1'b0;
    esr_done <= 1'b0;
  endtask : pulse

  task automatic t_regs();
    rdchk(REG_FB_DAC, 16'h000f);
    rdchk(REG_SHUNT, 16'h3999);
    chk(shunt_code, 16'h3999);
    rdchk(REG_ALARM_MASK, 16'h0000);
    rdchk(REG_MON_STATUS, 16'h0000);
    tick(200);
    rdchk(REG_ALARM, 16'h0000);
    rdchk(REG_MEAS_BASE + 8'(CH_DTEMP), 16'h0100);
    wr(8'h40, 16'hffff);
    rdchk(8'h40, 16'h0000);
    wr(REG_ALARM, 16'hffff);
    rdchk(REG_ALARM, 16'h0000);
    wr(REG_FB_DAC, 16'h0007);
    rdchk(REG_FB_DAC, 16'h0007);
    chk({12'h000, fb_ref_code}, 16'h0007);
    for (int i = 0; i < 4; i++) begin
      cell_sel <= 2'(i);
      tick(6);
      rdchk(REG_CELL_COUNT, 16'(i));
    end
    wr(REG_CTL, 16'h0002);
    tick(3);
    chk(16'(aux_buffer_en), 16'h0001);
    wr(REG_CTL, 16'h0000);
    tick(3);
    chk(16'(aux_buffer_en), 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_alarms();
    logic [15:0] b;
    for (int k = 0; k < NUM_ALARM; k++) begin
      b = 16'h0001 << k;
      adc_lat <= k[0] ? 4'h8 : 4'h1;
      wr(REG_LIMIT_BASE + 8'(k), ALARM_IS_OVER[k] ? 16'h0080 : 16'h0200);
      wr(REG_ALARM_MASK, b);
      poll(REG_ALARM, b, 200);
      chk(d, b);
      chk(16'(smbalert_oe), 16'h0001);
      pulse(0);
      tick(150);
      chk(16'(smbalert_oe), 16'h0000);
      rdchk(REG_ALARM, b);
      wr(REG_LIMIT_BASE + 8'(k), ALARM_IS_OVER[k] ? 16'h7fff : 16'h8000);
      wr(REG_ALARM_CLEAR, b);
      rdchk(REG_ALARM, 16'h0000);
    end
    wr(REG_ALARM_MASK, 16'h0000);
    $display("test alarms done");
  endtask : t_alarms

  task automatic t_cap_esr();
    wr(REG_MON_MASK, 16'h0002);
    wr(REG_CTL, 16'h0001);
    rdchk(REG_CTL, 16'h0000);
    rdchk(REG_MON_STATUS, 16'h0001);
    tick(20);
    chk(16'(discharge_en), 16'h0000);
    stack_charged_indicator <= 1'b1;
    wait_for(0, 1'b1);
    tick(1200);
    pulse(1);
    wait_for(1, 1'b1);
    chk(16'(smbalert_oe), 16'h0001);
    esr_value <= 17'h00fa0;
    pulse(2);
    wait_for(1, 1'b0);
    rdchk(REG_MON_STATUS, 16'h0006);
    rdchk(REG_ESR_RESULT, 16'h0fa0);
    chk({14'h0000, esr_current}, 16'h0002);
    rd(REG_CAP_RESULT, cap_coarse);
    chk(16'(cap_coarse > 16'h0003 && cap_coarse < 16'h0010), 16'h0001);
    pulse(0);
    // Fine scale and an ESR above the fail level
    wr(REG_CTL, 16'h0005);
    wait_for(0, 1'b1);
    tick(1200);
    pulse(1);
    wait_for(1, 1'b1);
    esr_value <= 17'h10001;
    pulse(2);
    wait_for(1, 1'b0);
    rd(REG_MON_STATUS, d);
    chk(d & 16'h0019, 16'h0010);
    rdchk(REG_ESR_RESULT, 16'h0fa0);
    rd(REG_CAP_RESULT, d);
    chk(16'(d > cap_coarse * 16'd40), 16'h0001);
    $display("test cap_esr done");
  endtask : t_cap_esr

  task automatic t_period_fail();
    wr(REG_PERIOD, 16'h0001);
    poll(REG_MON_STATUS, 16'h0001, 20);
    chk(d & 16'h0001, 16'h0001);
    wr(REG_PERIOD, 16'h0000);
    wait_for(0, 1'b1);
    power_fail <= 1'b1;
    wait_for(2, 1'b1);
    tick(3);
    rdchk(REG_MON_STATUS, 16'h0018);
    chk(16'(discharge_en), 16'h0000);
    power_fail <= 1'b0;
    wait_for(2, 1'b0);
    $display("test period_fail done");
  endtask : t_period_fail

  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    power_fail = 1'b0;
    stack_charged_indicator = 1'b0;
    cell_sel = 2'h0;
    ara_done = 1'b0;
    disch_done = 1'b0;
    esr_done = 1'b0;
    esr_value = 17'h00000;
    adc_vals = {11{16'h0100}};
    adc_lat = 4'h2;
    tick(8);
    resetn <= 1'b1;
    t_regs();
    t_alarms();
    t_cap_esr();
    t_period_fail();
    report_and_stop();
  end
endmodule : cem_monitor_bench
